// file: hdl/hppm_cfg.svh
// Constants for the host parallel port mailbox block
`ifndef HPPM_CFG_SVH
`define HPPM_CFG_SVH

`define HPPM_DATA_W 16
`define HPPM_MEM_AW 13
`define HPPM_SEL_DATA 2'h0
`define HPPM_SEL_MBOX 2'h1
`define HPPM_SEL_ADDR 2'h2
`define HPPM_SEL_STAT 2'h3
`define HPPM_WORD_STEP 16'h0002
`define HPPM_ZERO16 16'h0000
`define HPPM_STAT_OUT_BIT 0
`define HPPM_STAT_IN_BIT 1
`define HPPM_STAT_EN_BIT 2
`define HPPM_PTR_LSB 1
`define HPPM_FLAG_CLEAR 1'b0
`define HPPM_FLAG_SET 1'b1
`define HPPM_STROBE_IDLE 1'b1

`endif

// file: hdl/hppm_pkg.sv
// Types shared by the host parallel port mailbox block
package hppm_pkg;
  typedef enum logic [1:0] {
    HPPM_IDLE = 2'b00,
    HPPM_READ = 2'b01,
    HPPM_WRITE = 2'b10
  } hppm_phase_t;
endpackage

// file: hdl/hppm_strobe_edge.sv
// Rising-edge detector for one active-low strobe
`timescale 1ns/1ps
`include "hppm_cfg.svh"
module hppm_strobe_edge (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic strobe_n_in,
  output logic active_out,
  output logic release_out
);
  logic last_n_reg;
  logic last_n_next;

  always_comb begin
    last_n_next = strobe_n_in;
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      // Idle level, so leaving reset never looks like a release
      last_n_reg <= `HPPM_STROBE_IDLE;
    end else begin
      last_n_reg <= last_n_next;
    end
  end

  assign active_out = ~strobe_n_in;
  assign release_out = ~last_n_reg & strobe_n_in;
endmodule

// file: hdl/hppm_host_parallel_port.sv
// Host parallel port with memory window and two-way mailbox
`timescale 1ns/1ps
`include "hppm_cfg.svh"
module hppm_host_parallel_port (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic port_enable_in,
  input wire logic chip_select_n_in,
  input wire logic read_strobe_n_in,
  input wire logic write_strobe_n_in,
  input wire logic port_addr_hi_in,
  input wire logic port_addr_lo_in,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe_out,
  output logic mailbox_irq_out,
  input wire logic cpu_mbox_wr_in,
  input wire logic [15:0] cpu_mbox_data_in,
  input wire logic cpu_mbox_rd_in,
  output logic [15:0] cpu_mbox_data_out,
  output logic cpu_mbox_full_out,
  input wire logic cpu_mem_wr_in,
  input wire logic [12:0] cpu_mem_addr_in,
  input wire logic [15:0] cpu_mem_wdata_in,
  output logic [15:0] cpu_mem_rdata_out
);
  // ----------------------------------------
  // Strobe edges
  // ----------------------------------------
  // Pins are taken as synchronous to the core clock
  logic rd_active;
  logic rd_release;
  logic wr_release;
  logic [1:0] sel;
  logic sel_ok;

  hppm_strobe_edge u_rd (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .strobe_n_in(read_strobe_n_in),
    .active_out(rd_active),
    .release_out(rd_release)
  );

  // Write strobe level is not needed, only its release
  hppm_strobe_edge u_wr (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .strobe_n_in(write_strobe_n_in),
    .active_out(),
    .release_out(wr_release)
  );

  // Port is dead while pins belong to another function
  assign sel_ok = port_enable_in & ~chip_select_n_in;
  assign sel = {port_addr_hi_in, port_addr_lo_in};

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [15:0] mem [0:(1 << `HPPM_MEM_AW) - 1];
  logic [15:0] ptr_reg, ptr_next;
  logic [15:0] in_mbox_reg, in_mbox_next;
  logic [15:0] out_mbox_reg, out_mbox_next;
  // Incoming and outgoing message flags
  logic in_full_reg, in_full_next;
  logic out_full_reg, out_full_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [15:0] cpu_rdata_reg;
  logic host_rd_done;
  logic host_wr_done;
  logic host_mem_wr;
  logic [15:0] stat_word;
  hppm_pkg::hppm_phase_t access;

  // Pointer holds a byte address; memory is word wide
  function automatic logic [12:0] word_index(input logic [15:0] byte_addr);
    word_index = byte_addr[`HPPM_MEM_AW:`HPPM_PTR_LSB];
  endfunction

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  // Both strobes rising together breaks the bus rules; the write is
  // kept so that a host word is never lost for a read's side effect
  function automatic hppm_pkg::hppm_phase_t access_kind(
      input logic rd_done,
      input logic wr_done);
    if (wr_done) begin
      access_kind = hppm_pkg::HPPM_WRITE;
    end else if (rd_done) begin
      access_kind = hppm_pkg::HPPM_READ;
    end else begin
      access_kind = hppm_pkg::HPPM_IDLE;
    end
  endfunction

  // Capture on rising edge of strobe while select still low
  assign host_rd_done = rd_release & sel_ok;
  assign host_wr_done = wr_release & sel_ok;
  assign host_mem_wr = host_wr_done & (sel == `HPPM_SEL_DATA);
  assign access = access_kind(host_rd_done, host_wr_done);

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  always_comb begin
    stat_word = `HPPM_ZERO16;
    stat_word[`HPPM_STAT_OUT_BIT] = out_full_reg;
    stat_word[`HPPM_STAT_IN_BIT] = in_full_reg;
    stat_word[`HPPM_STAT_EN_BIT] = port_enable_in;
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    ptr_next = ptr_reg;
    in_mbox_next = in_mbox_reg;
    out_mbox_next = out_mbox_reg;
    in_full_next = in_full_reg;
    out_full_next = out_full_reg;
    rdata_next = rdata_reg;
    // Read data prefetched so the word is stable through the strobe
    case (sel)
      `HPPM_SEL_DATA: rdata_next = mem[word_index(ptr_reg)];
      `HPPM_SEL_MBOX: rdata_next = out_mbox_reg;
      `HPPM_SEL_ADDR: rdata_next = ptr_reg;
      `HPPM_SEL_STAT: rdata_next = stat_word;
      default: rdata_next = `HPPM_ZERO16;
    endcase
    // Clear before set so a same-cycle new message wins
    if (cpu_mbox_rd_in) begin
      in_full_next = `HPPM_FLAG_CLEAR;
    end
    case (access)
      hppm_pkg::HPPM_WRITE: begin
        case (sel)
          `HPPM_SEL_DATA: begin
            ptr_next = ptr_reg + `HPPM_WORD_STEP;
          end
          `HPPM_SEL_MBOX: begin
            in_mbox_next = data_in;
            in_full_next = `HPPM_FLAG_SET;
          end
          `HPPM_SEL_ADDR: begin
            ptr_next = data_in;
          end
          default: begin
            // Status is read-only; the write falls away
          end
        endcase
      end
      hppm_pkg::HPPM_READ: begin
        case (sel)
          `HPPM_SEL_DATA: begin
            ptr_next = ptr_reg + `HPPM_WORD_STEP;
          end
          `HPPM_SEL_MBOX: begin
            out_full_next = `HPPM_FLAG_CLEAR;
          end
          default: begin
            // Pointer and status reads leave no trace
          end
        endcase
      end
      default: begin
        // No access taken this cycle
      end
    endcase
    // Set after clear so a new outgoing message is never lost
    if (cpu_mbox_wr_in) begin
      out_mbox_next = cpu_mbox_data_in;
      out_full_next = `HPPM_FLAG_SET;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      ptr_reg <= `HPPM_ZERO16;
      in_mbox_reg <= `HPPM_ZERO16;
      out_mbox_reg <= `HPPM_ZERO16;
      in_full_reg <= `HPPM_FLAG_CLEAR;
      out_full_reg <= `HPPM_FLAG_CLEAR;
      rdata_reg <= `HPPM_ZERO16;
    end else begin
      ptr_reg <= ptr_next;
      in_mbox_reg <= in_mbox_next;
      out_mbox_reg <= out_mbox_next;
      in_full_reg <= in_full_next;
      out_full_reg <= out_full_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------
  // Shared memory, host write takes priority
  // ----------------------------------------
  // A CPU write in a host-write cycle is dropped; firmware must retry
  always_ff @(posedge core_clk_in) begin
    if (host_mem_wr) begin
      mem[word_index(ptr_reg)] <= data_in;
    end else if (cpu_mem_wr_in) begin
      mem[cpu_mem_addr_in] <= cpu_mem_wdata_in;
    end
    cpu_rdata_reg <= mem[cpu_mem_addr_in];
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign data_out = rdata_reg;
  // Enable dropped in reset so the pins never fight the host
  assign data_oe_out = sel_ok & rd_active & ~srst_in;
  // Interrupt masked while the pins are lent to another function
  assign mailbox_irq_out = out_full_reg & port_enable_in;
  assign cpu_mbox_data_out = in_mbox_reg;
  assign cpu_mbox_full_out = in_full_reg;
  assign cpu_mem_rdata_out = cpu_rdata_reg;
endmodule

// file: tb/hppm_port_checker_properties.sv
// Port checker for the host parallel port mailbox block
`timescale 1ns/1ps
module hppm_port_checker (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic port_enable_in,
  input wire logic chip_select_n_in,
  input wire logic read_strobe_n_in,
  input wire logic write_strobe_n_in,
  input wire logic port_addr_hi_in,
  input wire logic port_addr_lo_in,
  input wire logic [15:0] data_in,
  input wire logic [15:0] data_out,
  input wire logic data_oe_out,
  input wire logic mailbox_irq_out,
  input wire logic cpu_mbox_wr_in,
  input wire logic [15:0] cpu_mbox_data_in,
  input wire logic cpu_mbox_rd_in,
  input wire logic [15:0] cpu_mbox_data_out,
  input wire logic cpu_mbox_full_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  logic ok, mbx;
  logic [1:0] sel;
  assign ok = port_enable_in && !chip_select_n_in;
  assign sel = {port_addr_hi_in, port_addr_lo_in};
  assign mbx = ok && sel == 2'h1;
  oe_read_a:
    assert property (data_oe_out == (ok && !read_strobe_n_in))
    else $error("oe wrong");
  mbox_in_a:
    assert property ($rose(write_strobe_n_in) && mbx |=>
      cpu_mbox_full_out && cpu_mbox_data_out == $past(data_in))
    else $error("inbox wrong");
  irq_set_a:
    assert property (cpu_mbox_wr_in |=> mailbox_irq_out || !port_enable_in)
    else $error("irq not set");
  irq_clr_a:
    assert property ($rose(read_strobe_n_in) && mbx && !cpu_mbox_wr_in
      |=> !mailbox_irq_out)
    else $error("irq not cleared");
  inbox_ack_a:
    assert property (cpu_mbox_rd_in && !($rose(write_strobe_n_in) && mbx)
      |=> !cpu_mbox_full_out)
    else $error("ack ignored");
  refuse_a:
    assert property ($rose(cpu_mbox_full_out) |-> $past(mbx))
    else $error("refused write taken");
  status_a:
    assert property (sel == 2'h3 && $past(sel) == 2'h3 && !$past(srst_in)
      && $stable(port_enable_in)
      |-> data_out[15:2] == {13'h0000, port_enable_in})
    else $error("status wrong");
  outbox_rd_a:
    assert property (cpu_mbox_wr_in ##1 (sel == 2'h1 && !cpu_mbox_wr_in) [*2]
      |-> data_out == $past(cpu_mbox_data_in, 2))
    else $error("outbox wrong");
  cover property ($rose(mailbox_irq_out));
  cover property ($rose(cpu_mbox_full_out));
  cover property ($rose(write_strobe_n_in) && !port_enable_in);
endmodule
bind hppm_host_parallel_port hppm_port_checker hppm_port_checker_i (.*);

// file: tb/hppm_host_model.sv
// Host processor model driving the port strobes
`timescale 1ns/1ps
module hppm_host_model (
  input wire logic clk_in,
  input wire logic [15:0] rdata_in,
  output logic cs_n_out = 1'b1,
  output logic rd_n_out = 1'b1,
  output logic wr_n_out = 1'b1,
  output logic [1:0] sel_out = 2'h0,
  output logic [15:0] wdata_out = 16'h0000
);
  // Enter just after an edge; chip select outlasts the strobe one edge
  task automatic acc(input logic wr, input logic [1:0] sel,
      input logic [15:0] wd, output logic [15:0] rd);
    sel_out = sel;
    wdata_out = wd;
    cs_n_out = 1'b0;
    rd_n_out = wr;
    wr_n_out = !wr;
    repeat (3) @(posedge clk_in);
    #1;
    // Word taken while the strobe still holds it, clear of the edge
    rd = rdata_in;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    @(posedge clk_in);
    #1;
    // Released lines must not keep showing the old word
    cs_n_out = 1'b1;
    wdata_out = ~wd;
    repeat (2) @(posedge clk_in);
    #1;
  endtask
endmodule

// file: tb/hppm_host_parallel_port_test.sv
// Self-checking bench for the host parallel port mailbox block
`timescale 1ns/1ps
module hppm_host_parallel_port_test;
  logic core_clk_in, srst_in, en, cs_n, rd_n, wr_n, oe, irq, mwr, mrd;
  logic full, memwr;
  logic [1:0] sel;
  logic [12:0] maddr;
  logic [15:0] wd, dout, bus, mdat, mbi, mwd, mrdat, r;
  int mismatches = 0;
  int n_checks = 0;
  assign bus = oe ? dout : wd;
  hppm_host_parallel_port hppm_host_parallel_port_i (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .port_enable_in(en),
    .chip_select_n_in(cs_n), .read_strobe_n_in(rd_n),
    .write_strobe_n_in(wr_n), .port_addr_hi_in(sel[1]),
    .port_addr_lo_in(sel[0]), .data_in(bus), .data_out(dout),
    .data_oe_out(oe), .mailbox_irq_out(irq), .cpu_mbox_wr_in(mwr),
    .cpu_mbox_data_in(mdat), .cpu_mbox_rd_in(mrd),
    .cpu_mbox_data_out(mbi), .cpu_mbox_full_out(full),
    .cpu_mem_wr_in(memwr), .cpu_mem_addr_in(maddr),
    .cpu_mem_wdata_in(mwd), .cpu_mem_rdata_out(mrdat));
  hppm_host_model hppm_host_model_i (.clk_in(core_clk_in), .rdata_in(bus),
    .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n), .sel_out(sel),
    .wdata_out(wd));
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hw(input logic [1:0] s, input logic [15:0] v);
    hppm_host_model_i.acc(1'b1, s, v, r);
  endtask
  task automatic hr(input logic [1:0] s, input string nm, logic [15:0] e);
    hppm_host_model_i.acc(1'b0, s, 16'h0000, r);
    chk(nm, e, r);
  endtask
  task automatic tick;
    @(posedge core_clk_in);
    #1;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  initial begin
    srst_in = 1'b1;
    en = 1'b1;
    {mwr, mrd, memwr} = 3'h0;
    {mdat, maddr, mwd} = {16'h3c5a, 13'h0008, 16'h1234};
    repeat (2) tick;
    srst_in = 1'b0;
    hr(2'h3, "status", 16'h0004);
    hw(2'h2, 16'h0010);
    hw(2'h0, 16'hbeef);
    hw(2'h0, 16'h0bad);
    hr(2'h2, "pointer", 16'h0014);
    hw(2'h2, 16'h0010);
    hr(2'h0, "word0", 16'hbeef);
    hr(2'h0, "word1", 16'h0bad);
    chk("cpu word", 16'hbeef, mrdat);
    {memwr, maddr} = {1'b1, 13'h0020};
    tick;
    memwr = 1'b0;
    hw(2'h2, 16'h0040);
    hr(2'h0, "cpu wrote", 16'h1234);
    $display("test memory window done");
    hw(2'h1, 16'ha5c3);
    chk("inbox", 16'ha5c3, mbi);
    mwr = 1'b1;
    tick;
    mwr = 1'b0;
    tick;
    chk("irq", 16'h0001, {15'h0000, irq});
    hr(2'h3, "status", 16'h0007);
    mrd = 1'b1;
    tick;
    mrd = 1'b0;
    tick;
    chk("inbox flag", 16'h0000, {15'h0000, full});
    hr(2'h1, "outbox", 16'h3c5a);
    chk("irq", 16'h0000, {15'h0000, irq});
    $display("test mailbox done");
    en = 1'b0;
    hw(2'h2, 16'h0100);
    en = 1'b1;
    hr(2'h2, "pointer", 16'h0042);
    $display("test refusal done");
    summarize;
  end
endmodule
